/* forward_config_audio_status_regs.sv */
`timescale 1ns/1ps

// Notes on behaviour
// - Override bit set blocks forward-channel loading of all bits but dual-link; local writes stay intact.
// - Video-off flag reads 1 when no active video; control stays operational.
// - While override set, video-off flag holds and ignores forward updates.
// - Dual-link flag is read-only, always loaded from the forward channel.
// - Alternate audio bit drives extra audio output on the two GPIOs.
// - Sync-in-stream bit means forward channel carries 28-bit video with syncs.
// - Surround bit enables surround audio output and is remotely loadable.
// - Receive FIFO overrun is reported in read-only audio bit 3.
// - Receive FIFO underrun is reported in read-only audio bit 2.
// - Writing 1 to the error reset bit clears both FIFO error flags.
// - Edge select 1 strobes data on rising edge, 0 on falling.
// - Pixel clock test bit 7 selects the test clock input pin.
// - With lock mode 0, lock asserts only while video-off flag is 0.
module forward_config_audio_status_regs
  import fwd_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // Local register port
  input wire reg_req_t reg_req_in,
  output logic [7:0] rd_data_out,
  output logic rd_valid_out,
  // Forward channel configuration load
  input wire fwd_load_t fwd_load_in,
  // Link status and lock mode
  input wire logic link_up_in,
  input wire logic lock_mode_in,
  // Audio receive FIFO events
  input wire logic fifo_overrun_in,
  input wire logic fifo_underrun_in,
  // Audio data and word clock for the alternate output
  input wire logic audio_data_in,
  input wire logic audio_word_clk_in,
  // Test clock pin level, used only as a select indication
  input wire logic test_clock_input_in,
  // Configuration outputs
  output dp_cfg_t cfg_out,
  output logic video_off_out,
  output logic dual_link_out,
  output logic rx_lock_out,
  // Alternate audio pins, GPIO1 word clock and GPIO0 data
  output logic gpio0_out,
  output logic gpio0_oe_out,
  output logic gpio1_out,
  output logic gpio1_oe_out,
  output logic test_clock_level_out
);

  // ==========================================================================
  // Register state
  logic [7:0] dp_ctrl_ff;
  logic [7:0] aud_ctrl_ff;
  logic [7:0] pclk_test_ff;
  logic [7:0] rd_data_ff;
  logic rd_valid_ff;
  dp_cfg_t cfg_ff;
  logic video_off_ff;
  logic dual_link_ff;
  logic rx_lock_ff;
  logic gpio0_ff;
  logic gpio0_oe_ff;
  logic gpio1_ff;
  logic gpio1_oe_ff;
  logic [1:0] test_clk_sync_ff;
  logic [1:0] link_sync_ff;
  logic [1:0] data_sync_ff;
  logic [1:0] wclk_sync_ff;
  logic test_clock_level_ff;

  logic [7:0] nxt_dp_ctrl;
  logic [7:0] nxt_aud_ctrl;
  logic [7:0] nxt_pclk_test;
  logic [7:0] nxt_rd_data;
  logic nxt_rx_lock;
  logic overrun_flag;
  logic underrun_flag;

  // ==========================================================================
  // Decode
  wire wr_dp = reg_req_in.wr_en && (reg_req_in.addr == DP_CTRL2_ADDR);
  wire wr_aud = reg_req_in.wr_en && (reg_req_in.addr == AUD_CTRL_ADDR);
  wire wr_pclk = reg_req_in.wr_en && (reg_req_in.addr == PCLK_TEST_ADDR);
  wire override_remote_config = dp_ctrl_ff[DP_OVERRIDE_BIT];
  wire fwd_take = fwd_load_in.load && !override_remote_config;
  wire err_clear = wr_aud && reg_req_in.wdata[AUD_ERR_CLR_BIT];

  // Datapath register: a local write changes only the writable bits. The
  // dual-link flag is always taken from the forward channel, even under override.
  always_comb
  begin
    nxt_dp_ctrl = dp_ctrl_ff;
    if (wr_dp)
    begin
      nxt_dp_ctrl = (reg_req_in.wdata & DP_LOCAL_MASK) | (dp_ctrl_ff & ~DP_LOCAL_MASK);
    end
    if (fwd_take)
    begin
      nxt_dp_ctrl[DP_VIDEO_OFF_BIT:0] = fwd_load_in.cfg[DP_VIDEO_OFF_BIT:0];
    end
    if (fwd_load_in.load)
    begin
      nxt_dp_ctrl[DP_DUAL_LINK_BIT] = fwd_load_in.cfg[DP_DUAL_LINK_BIT];
    end
  end

  // Status bits are not stored here; they come from the sticky flag module.
  assign nxt_aud_ctrl = wr_aud ? (reg_req_in.wdata & AUD_WRITE_MASK) : aud_ctrl_ff;
  assign nxt_pclk_test = wr_pclk ? reg_req_in.wdata : pclk_test_ff;

  always_comb
  begin
    nxt_rd_data = 8'h00;
    case (reg_req_in.addr)
      DP_CTRL2_ADDR: nxt_rd_data = dp_ctrl_ff;
      AUD_CTRL_ADDR:
      begin
        nxt_rd_data = aud_ctrl_ff;
        nxt_rd_data[AUD_OVERRUN_BIT] = overrun_flag;
        nxt_rd_data[AUD_UNDERRUN_BIT] = underrun_flag;
      end
      PCLK_TEST_ADDR: nxt_rd_data = pclk_test_ff;
      default: nxt_rd_data = 8'h00;
    endcase
  end

  // Lock mode 1 accepts any link; mode 0 also needs active video.
  assign nxt_rx_lock = link_sync_ff[1] && (lock_mode_in || !dp_ctrl_ff[DP_VIDEO_OFF_BIT]);

  // ==========================================================================
  // Sticky FIFO error flags
  audio_err_flags u_err_flags (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .overrun_in(fifo_overrun_in),
    .underrun_in(fifo_underrun_in),
    .clear_in(err_clear),
    .overrun_out(overrun_flag),
    .underrun_out(underrun_flag)
  );

  // ==========================================================================
  // Registers
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      dp_ctrl_ff <= DP_CTRL2_RESET;
      aud_ctrl_ff <= AUD_CTRL_RESET;
      pclk_test_ff <= PCLK_TEST_RESET;
      rd_data_ff <= 8'h00;
      rd_valid_ff <= 1'b0;
    end
    else
    begin
      dp_ctrl_ff <= nxt_dp_ctrl;
      aud_ctrl_ff <= nxt_aud_ctrl;
      pclk_test_ff <= nxt_pclk_test;
      rd_data_ff <= nxt_rd_data;
      rd_valid_ff <= reg_req_in.rd_en;
    end
  end

  // Pin inputs pass two flip-flops before use.
  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      test_clk_sync_ff <= 2'h0;
      link_sync_ff <= 2'h0;
      data_sync_ff <= 2'h0;
      wclk_sync_ff <= 2'h0;
    end
    else
    begin
      test_clk_sync_ff <= {test_clk_sync_ff[0], test_clock_input_in};
      link_sync_ff <= {link_sync_ff[0], link_up_in};
      data_sync_ff <= {data_sync_ff[0], audio_data_in};
      wclk_sync_ff <= {wclk_sync_ff[0], audio_word_clk_in};
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      cfg_ff <= '0;
      video_off_ff <= 1'b0;
      dual_link_ff <= 1'b0;
      rx_lock_ff <= 1'b0;
      gpio0_ff <= 1'b0;
      gpio0_oe_ff <= 1'b0;
      gpio1_ff <= 1'b0;
      gpio1_oe_ff <= 1'b0;
      test_clock_level_ff <= 1'b0;
    end
    else
    begin
      cfg_ff.alt_audio_en <= dp_ctrl_ff[DP_ALT_AUDIO_BIT];
      cfg_ff.audio_off <= dp_ctrl_ff[DP_AUDIO_OFF_BIT];
      cfg_ff.sync_in_stream_en <= dp_ctrl_ff[DP_SYNC_IN_BIT];
      cfg_ff.surround_en <= dp_ctrl_ff[DP_SURROUND_BIT];
      cfg_ff.rise_edge_strobe <= aud_ctrl_ff[AUD_RISE_EDGE_BIT];
      cfg_ff.test_clock_sel <= pclk_test_ff[PCLK_EXT_SEL_BIT];
      video_off_ff <= dp_ctrl_ff[DP_VIDEO_OFF_BIT];
      dual_link_ff <= dp_ctrl_ff[DP_DUAL_LINK_BIT];
      rx_lock_ff <= nxt_rx_lock;
      gpio0_oe_ff <= dp_ctrl_ff[DP_ALT_AUDIO_BIT];
      gpio1_oe_ff <= dp_ctrl_ff[DP_ALT_AUDIO_BIT];
      gpio0_ff <= dp_ctrl_ff[DP_ALT_AUDIO_BIT] & data_sync_ff[1];
      gpio1_ff <= dp_ctrl_ff[DP_ALT_AUDIO_BIT] & wclk_sync_ff[1];
      test_clock_level_ff <= pclk_test_ff[PCLK_EXT_SEL_BIT] & test_clk_sync_ff[1];
    end
  end

  assign rd_data_out = rd_data_ff;
  assign rd_valid_out = rd_valid_ff;
  assign cfg_out = cfg_ff;
  assign video_off_out = video_off_ff;
  assign dual_link_out = dual_link_ff;
  assign rx_lock_out = rx_lock_ff;
  assign gpio0_out = gpio0_ff;
  assign gpio0_oe_out = gpio0_oe_ff;
  assign gpio1_out = gpio1_ff;
  assign gpio1_oe_out = gpio1_oe_ff;
  assign test_clock_level_out = test_clock_level_ff;

  // ==========================================================================
  // Checks
  sequence override_and_load;
    override_remote_config && fwd_load_in.load && !wr_dp;
  endsequence

  sequence remote_load_taken;
    fwd_load_in.load && !override_remote_config;
  endsequence

  a_override_blocks_load: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    override_and_load |=>
    dp_ctrl_ff[DP_ALT_AUDIO_BIT:0] == $past(dp_ctrl_ff[DP_ALT_AUDIO_BIT:0]))
    else $error("Forward load changed config under override.");

  a_surround_load: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    remote_load_taken |=>
    dp_ctrl_ff[DP_SURROUND_BIT] == $past(fwd_load_in.cfg[DP_SURROUND_BIT]))
    else $error("Surround bit not loaded from forward channel.");

  a_video_off_hold: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    override_and_load |=> $stable(dp_ctrl_ff[DP_VIDEO_OFF_BIT]))
    else $error("Video-off flag changed under override.");

  a_video_off_load: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    fwd_load_in.load && !override_remote_config |=> ##1
    video_off_out == $past(fwd_load_in.cfg[DP_VIDEO_OFF_BIT], 2))
    else $error("Video-off flag not loaded from forward channel.");

  a_dual_link_ro: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    wr_dp && !fwd_load_in.load |=> $stable(dp_ctrl_ff[DP_DUAL_LINK_BIT]))
    else $error("Dual-link flag changed by a local write.");

  // Override must not stop the dual-link flag from following the far side.
  a_dual_link_load: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    fwd_load_in.load |=>
    dp_ctrl_ff[DP_DUAL_LINK_BIT] == $past(fwd_load_in.cfg[DP_DUAL_LINK_BIT]))
    else $error("Dual-link flag not loaded from forward channel.");

  a_alt_audio_pins: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    gpio0_oe_out |-> $past(dp_ctrl_ff[DP_ALT_AUDIO_BIT]))
    else $error("Alternate audio pins driven while disabled.");

  a_gpio_follows_audio: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    dp_ctrl_ff[DP_ALT_AUDIO_BIT] |=> gpio0_oe_out && gpio1_oe_out &&
    gpio0_out == $past(data_sync_ff[1]) && gpio1_out == $past(wclk_sync_ff[1]))
    else $error("Alternate audio pins do not carry the audio signals.");

  a_edge_select_load: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    wr_aud |=> ##1 cfg_out.rise_edge_strobe == $past(reg_req_in.wdata[AUD_RISE_EDGE_BIT], 2))
    else $error("Edge select output does not follow the written bit.");

  a_pclk_select_load: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    wr_pclk |=> ##1 cfg_out.test_clock_sel == $past(reg_req_in.wdata[PCLK_EXT_SEL_BIT], 2))
    else $error("Test clock select does not follow the written bit.");

  a_err_clear_both: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    err_clear && !fifo_overrun_in && !fifo_underrun_in |=> !overrun_flag && !underrun_flag)
    else $error("Error reset left a FIFO flag set.");

  a_overrun_read: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    reg_req_in.addr == AUD_CTRL_ADDR |=> rd_data_out[AUD_OVERRUN_BIT] == $past(overrun_flag))
    else $error("Overrun status read back wrong.");

  a_underrun_read: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    reg_req_in.addr == AUD_CTRL_ADDR |=> rd_data_out[AUD_UNDERRUN_BIT] == $past(underrun_flag))
    else $error("Underrun status read back wrong.");

  a_lock_needs_video: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    !lock_mode_in && dp_ctrl_ff[DP_VIDEO_OFF_BIT] |=> !rx_lock_out)
    else $error("Lock asserted without active video in mode 0.");

  a_lock_mode_one: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    lock_mode_in && link_sync_ff[1] |=> rx_lock_out)
    else $error("Lock missing in mode 1 with the link up.");

endmodule : forward_config_audio_status_regs

/* fwd_cfg_pkg.sv */
package fwd_cfg_pkg;

  // ==========================================================================
  // Register offsets
  localparam logic [7:0] DP_CTRL2_ADDR = 8'h28;
  localparam logic [7:0] AUD_CTRL_ADDR = 8'h2B;
  localparam logic [7:0] PCLK_TEST_ADDR = 8'h2E;

  // ==========================================================================
  // Field positions in the datapath control register
  localparam int DP_OVERRIDE_BIT = 7;
  localparam int DP_VIDEO_OFF_BIT = 5;
  localparam int DP_DUAL_LINK_BIT = 4;
  localparam int DP_ALT_AUDIO_BIT = 3;
  localparam int DP_AUDIO_OFF_BIT = 2;
  localparam int DP_SYNC_IN_BIT = 1;
  localparam int DP_SURROUND_BIT = 0;

  // ==========================================================================
  // Field positions and write mask in the audio control register
  localparam int AUD_OVERRUN_BIT = 3;
  localparam int AUD_UNDERRUN_BIT = 2;
  localparam int AUD_ERR_CLR_BIT = 1;
  localparam int AUD_RISE_EDGE_BIT = 0;
  localparam logic [7:0] AUD_WRITE_MASK = 8'hF3;

  // ==========================================================================
  // Field positions in the pixel clock test register
  localparam int PCLK_EXT_SEL_BIT = 7;

  // ==========================================================================
  // Reset values and the datapath local write mask
  localparam logic [7:0] DP_CTRL2_RESET = 8'h00;
  localparam logic [7:0] AUD_CTRL_RESET = 8'h00;
  localparam logic [7:0] PCLK_TEST_RESET = 8'h00;
  localparam logic [7:0] DP_LOCAL_MASK = 8'hEF;

  // ==========================================================================
  // Local register access, forward-channel load and configuration outputs
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic load;
    logic [7:0] cfg;
  } fwd_load_t;

  typedef struct packed {
    logic alt_audio_en;
    logic audio_off;
    logic sync_in_stream_en;
    logic surround_en;
    logic rise_edge_strobe;
    logic test_clock_sel;
  } dp_cfg_t;

endpackage : fwd_cfg_pkg

/* audio_err_flags.sv */
`timescale 1ns/1ps

module audio_err_flags
  import fwd_cfg_pkg::*;
(
  // Clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // Events and clear
  input wire logic overrun_in,
  input wire logic underrun_in,
  input wire logic clear_in,
  // Sticky flags
  output logic overrun_out,
  output logic underrun_out
);

  logic overrun_ff;
  logic underrun_ff;
  logic nxt_overrun;
  logic nxt_underrun;

  // A new event beats a simultaneous clear so that it is never lost.
  assign nxt_overrun = overrun_in | (overrun_ff & ~clear_in);
  assign nxt_underrun = underrun_in | (underrun_ff & ~clear_in);

  always_ff @(posedge clock_in)
  begin
    if (sys_rst_in)
    begin
      overrun_ff <= 1'b0;
      underrun_ff <= 1'b0;
    end
    else
    begin
      overrun_ff <= nxt_overrun;
      underrun_ff <= nxt_underrun;
    end
  end

  assign overrun_out = overrun_ff;
  assign underrun_out = underrun_ff;

  a_flag_sticky: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    overrun_ff && !clear_in |=> overrun_ff)
    else $error("Overrun flag dropped without a clear.");

  a_clear_works: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    clear_in && !underrun_in |=> !underrun_ff)
    else $error("Underrun flag survived a clear.");

  a_set_beats_clear: assert property (@(posedge clock_in) disable iff (sys_rst_in)
    overrun_in |=> overrun_ff)
    else $error("Overrun event lost.");

endmodule : audio_err_flags

/* remote_ser_model.sv */
`timescale 1ns/1ps

// ==========================================================================
// Remote serializer model: sends configuration bytes down the forward channel.
module remote_ser_model
  import fwd_cfg_pkg::*;
(
  // Clock
  input wire logic clock_in,
  // Forward channel load
  output fwd_load_t fwd_out
);
  initial fwd_out = '0;

  // Between loads the byte shows the inverse of the last one, so stale data never matches.
  task automatic send(input logic [7:0] cfg);
    @(negedge clock_in);
    fwd_out.load = 1'b1;
    fwd_out.cfg = cfg;
    @(negedge clock_in);
    fwd_out.load = 1'b0;
    fwd_out.cfg = ~cfg;
  endtask : send
endmodule : remote_ser_model

/* testbench.sv */
`timescale 1ns/1ps

module testbench
  import fwd_cfg_pkg::*;
;
  logic clock_in = 1'b0;
  logic sys_rst_in = 1'b1;
  reg_req_t reg_req_in = '0;
  fwd_load_t fwd_load_in;
  logic link_up_in = 1'b0;
  logic lock_mode_in = 1'b0;
  logic fifo_overrun_in = 1'b0;
  logic fifo_underrun_in = 1'b0;
  logic audio_data_in = 1'b0;
  logic audio_word_clk_in = 1'b0;
  logic test_clock_input_in = 1'b0;
  logic [7:0] rd_data_out;
  logic rd_valid_out;
  dp_cfg_t cfg_out;
  logic video_off_out, dual_link_out, rx_lock_out, test_clock_level_out;
  logic gpio0_out, gpio0_oe_out, gpio1_out, gpio1_oe_out;
  int n_fail = 0;
  int check_count = 0;
  int cycles = 0;

  always #4 clock_in = ~clock_in;

  forward_config_audio_status_regs dut_u (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .reg_req_in(reg_req_in),
    .rd_data_out(rd_data_out), .rd_valid_out(rd_valid_out), .fwd_load_in(fwd_load_in),
    .link_up_in(link_up_in), .lock_mode_in(lock_mode_in),
    .fifo_overrun_in(fifo_overrun_in), .fifo_underrun_in(fifo_underrun_in),
    .audio_data_in(audio_data_in), .audio_word_clk_in(audio_word_clk_in),
    .test_clock_input_in(test_clock_input_in), .cfg_out(cfg_out),
    .video_off_out(video_off_out), .dual_link_out(dual_link_out), .rx_lock_out(rx_lock_out),
    .gpio0_out(gpio0_out), .gpio0_oe_out(gpio0_oe_out), .gpio1_out(gpio1_out),
    .gpio1_oe_out(gpio1_oe_out), .test_clock_level_out(test_clock_level_out));

  remote_ser_model partner_u (.clock_in(clock_in), .fwd_out(fwd_load_in));

  // ==========================================================================
  // Access tasks.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge clock_in);
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clock_in);
    reg_req_in = '{wr_en: 1'b1, rd_en: 1'b0, addr: a, wdata: d};
    @(negedge clock_in);
    reg_req_in.wr_en = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clock_in);
    reg_req_in = '{wr_en: 1'b0, rd_en: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clock_in);
    reg_req_in.rd_en = 1'b0;
    chk({7'h00, rd_valid_out}, 8'h01);
    chk(rd_data_out, exp);
  endtask : rd

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : final_report

  // A hang is cut off at 3000 cycles, well beyond the fewer than 100 cycles the tests need.
  always @(posedge clock_in)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      n_fail++;
      final_report();
    end
  end

  // ==========================================================================
  // Test sequence.
  initial
  begin
    cyc(10);
    sys_rst_in = 1'b0;
    rd(DP_CTRL2_ADDR, DP_CTRL2_RESET);
    rd(AUD_CTRL_ADDR, AUD_CTRL_RESET);
    rd(PCLK_TEST_ADDR, PCLK_TEST_RESET);
    chk({2'h0, cfg_out}, 8'h00);
    link_up_in = 1'b1;
    cyc(6);
    chk({7'h00, rx_lock_out}, 8'h01);
    partner_u.send(8'h20);
    cyc(2);
    chk({7'h00, video_off_out}, 8'h01);
    chk({7'h00, rx_lock_out}, 8'h00);
    lock_mode_in = 1'b1;
    cyc(2);
    chk({7'h00, rx_lock_out}, 8'h01);
    lock_mode_in = 1'b0;
    rd(DP_CTRL2_ADDR, 8'h20);
    partner_u.send(8'h3F);
    cyc(2);
    chk({7'h00, dual_link_out}, 8'h01);
    rd(DP_CTRL2_ADDR, 8'h3F);
    wr(DP_CTRL2_ADDR, 8'h00);
    rd(DP_CTRL2_ADDR, 8'h10);
    wr(DP_CTRL2_ADDR, 8'h80);
    partner_u.send(8'h2F);
    cyc(2);
    chk({7'h00, video_off_out}, 8'h00);
    rd(DP_CTRL2_ADDR, 8'h80);
    chk({6'h00, gpio1_oe_out, gpio0_oe_out}, 8'h00);
    audio_data_in = 1'b1;
    wr(DP_CTRL2_ADDR, 8'h0B);
    cyc(4);
    chk({2'h0, cfg_out}, 8'h2C);
    chk({4'h0, gpio1_oe_out, gpio1_out, gpio0_oe_out, gpio0_out}, 8'h0B);
    fifo_overrun_in = 1'b1;
    cyc(1);
    fifo_overrun_in = 1'b0;
    rd(AUD_CTRL_ADDR, 8'h08);
    fifo_underrun_in = 1'b1;
    cyc(1);
    fifo_underrun_in = 1'b0;
    rd(AUD_CTRL_ADDR, 8'h0C);
    fifo_overrun_in = 1'b1;
    wr(AUD_CTRL_ADDR, 8'h0F);
    fifo_overrun_in = 1'b0;
    rd(AUD_CTRL_ADDR, 8'h0B);
    wr(AUD_CTRL_ADDR, 8'h0F);
    rd(AUD_CTRL_ADDR, 8'h03);
    chk({7'h00, cfg_out.rise_edge_strobe}, 8'h01);
    test_clock_input_in = 1'b1;
    cyc(4);
    chk({7'h00, test_clock_level_out}, 8'h00);
    wr(PCLK_TEST_ADDR, 8'h80);
    cyc(4);
    chk({6'h00, cfg_out.test_clock_sel, test_clock_level_out}, 8'h03);
    rd(PCLK_TEST_ADDR, 8'h80);
    wr(8'h29, 8'hFF);
    rd(8'h29, 8'h00);
    final_report();
  end
endmodule : testbench
